// ### design/hetap_regs.sv
// Design: echo tap coefficient registers behind an AXI4-Lite slave
//
// The AXI4-Lite slave port was decided locally.
`timescale 1ns/10ps
module hetap_regs
  import hetap_pkg::*;
#(
  parameter int ADDR_W = 10
) (
  input  wire logic              clk_i,
  input  wire logic              nrst_i,
  input  wire logic              sample_stb_i,
  output hetap_coeff_t           coeffs_o,
  output logic [NTAPS-1:0]       tap_active_o,
  output logic                   pending_o,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [DATA_W-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // ****************************************
  // Elaboration check
  // ****************************************
  if (ADDR_W < 10) begin : g_chk
    $error("ADDR_W must be at least 10");
  end

  // ****************************************
  // Address decode
  // ****************************************
  // Returns {hit, tap number}; word aligned only
  function automatic logic [2:0] tap_decode(
    input logic [ADDR_W-1:0] addr
  );
    logic [ADDR_W-1:0] idx;
    idx = addr >> 2;
    tap_decode = 3'h0;
    if (addr[1:0] == 2'h0) begin
      if (idx == ADDR_W'(IDX_TAP1)) tap_decode = 3'h4;
      if (idx == ADDR_W'(IDX_TAP2)) tap_decode = 3'h5;
      if (idx == ADDR_W'(IDX_TAP3)) tap_decode = 3'h6;
      if (idx == ADDR_W'(IDX_TAP4)) tap_decode = 3'h7;
    end
  endfunction : tap_decode

  // Status register hit
  function automatic logic stat_hit(input logic [ADDR_W-1:0] addr);
    stat_hit = (addr == ADDR_W'({IDX_STATUS, 2'h0}));
  endfunction : stat_hit

  // ****************************************
  // Write channel state
  // ****************************************
  logic              aw_full;
  logic [ADDR_W-1:0] aw_addr;
  logic              w_full;
  logic [COEF_W-1:0] w_byte;
  logic              w_lane0;
  logic              next_aw_full;
  logic [ADDR_W-1:0] next_aw_addr;
  logic              next_w_full;
  logic [COEF_W-1:0] next_w_byte;
  logic              next_w_lane0;
  logic              next_awready;
  logic              next_wready;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              do_wr;
  logic [2:0]        wr_dec;

  // Address and data may come in either order
  always_comb begin
    next_aw_full = aw_full;
    next_aw_addr = aw_addr;
    next_w_full  = w_full;
    next_w_byte  = w_byte;
    next_w_lane0 = w_lane0;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    do_wr        = aw_full && w_full && !s_axi_bvalid;
    wr_dec       = tap_decode(aw_addr);
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_full = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_full  = 1'b1;
      next_w_byte  = s_axi_wdata[COEF_W-1:0];
      next_w_lane0 = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (do_wr) begin
      next_aw_full = 1'b0;
      next_w_full  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (wr_dec[2] || stat_hit(aw_addr)) ? RESP_OK : RESP_DEC;
    end
    next_awready = !next_aw_full && !next_bvalid;
    next_wready  = !next_w_full && !next_bvalid;
  end

  // Write channel registers
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      aw_full       <= 1'b0;
      aw_addr       <= '0;
      w_full        <= 1'b0;
      w_byte        <= COEF_RST;
      w_lane0       <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OK;
    end else begin
      aw_full       <= next_aw_full;
      aw_addr       <= next_aw_addr;
      w_full        <= next_w_full;
      w_byte        <= next_w_byte;
      w_lane0       <= next_w_lane0;
      s_axi_awready <= next_awready;
      s_axi_wready  <= next_wready;
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
    end
  end

  // ****************************************
  // Coefficient storage
  // ****************************************
  hetap_coeff_t coef;
  hetap_coeff_t next_coef;
  logic         next_pending;

  // Software write into one tap; pending set wins over sample clear
  always_comb begin
    next_coef    = coef;
    next_pending = pending_o;
    if (sample_stb_i) begin
      next_pending = 1'b0;
    end
    if (do_wr && wr_dec[2] && w_lane0) begin
      next_coef.tap[wr_dec[1:0]] = w_byte;
      next_pending = 1'b1;
    end
  end

  // Coefficient registers, cleared on reset
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      coef      <= '0;
      pending_o <= 1'b0;
    end else begin
      coef      <= next_coef;
      pending_o <= next_pending;
    end
  end

  // ****************************************
  // Values applied to the filter datapath
  // ****************************************
  hetap_coeff_t     next_coeffs;
  logic [NTAPS-1:0] next_active;

  // Latch at each sample start; zero tap disabled
  always_comb begin
    next_coeffs = coeffs_o;
    next_active = tap_active_o;
    if (sample_stb_i) begin
      next_coeffs = coef;
      for (int i = 0; i < NTAPS; i++) begin
        next_active[i] = (coef.tap[i] != COEF_RST);
      end
    end
  end

  // Applied value registers
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      coeffs_o     <= '0;
      tap_active_o <= '0;
    end else begin
      coeffs_o     <= next_coeffs;
      tap_active_o <= next_active;
    end
  end

  // ****************************************
  // Read channel
  // ****************************************
  logic              next_arready;
  logic              next_rvalid;
  logic [DATA_W-1:0] next_rdata;
  logic [1:0]        next_rresp;
  logic [2:0]        rd_dec;

  // Answer one cycle after the address is taken
  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    rd_dec      = tap_decode(s_axi_araddr);
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OK;
      next_rdata  = '0;
      if (rd_dec[2]) begin
        next_rdata[COEF_W-1:0] = coef.tap[rd_dec[1:0]];
      end else if (stat_hit(s_axi_araddr)) begin
        next_rdata[STAT_PEND] = pending_o;
      end else begin
        next_rresp = RESP_DEC;
      end
    end
    next_arready = !next_rvalid;
  end

  // Read channel registers
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OK;
    end else begin
      s_axi_arready <= next_arready;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_tap1_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
    do_wr && w_lane0 && wr_dec == 3'h4 |=> coef.tap[0] == $past(w_byte))
    else $error("tap 1 write lost");

  a_tap2_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
    do_wr && w_lane0 && wr_dec == 3'h5 |=> coef.tap[1] == $past(w_byte))
    else $error("tap 2 write lost");

  a_tap3_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
    do_wr && w_lane0 && wr_dec == 3'h6 |=> coef.tap[2] == $past(w_byte))
    else $error("tap 3 write lost");

  a_tap4_write: assert property (@(posedge clk_i) disable iff (!nrst_i)
    do_wr && w_lane0 && wr_dec == 3'h7 |=> coef.tap[3] == $past(w_byte))
    else $error("tap 4 write lost");

  a_zero_tap_off: assert property (@(posedge clk_i) disable iff (!nrst_i)
    sample_stb_i && coef.tap[0] == COEF_RST |=> !tap_active_o[0]
      && coeffs_o.tap[0] == COEF_RST)
    else $error("zero tap still active");

  a_reset_clear: assert property (@(posedge clk_i)
    !nrst_i |=> coef == '0 && coeffs_o == '0 && tap_active_o == '0)
    else $error("coefficients not cleared by reset");

  a_read_back: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_axi_arvalid && s_axi_arready && rd_dec[2] && !s_axi_rvalid
      |=> s_axi_rvalid && s_axi_rresp == RESP_OK
      && s_axi_rdata == DATA_W'($past(coef.tap[rd_dec[1:0]])))
    else $error("read data differs from register");

  a_apply_next: assert property (@(posedge clk_i) disable iff (!nrst_i)
    sample_stb_i |=> coeffs_o == $past(coef) && (pending_o == $past(do_wr && wr_dec[2]
      && w_lane0)))
    else $error("sample did not apply coefficients");

  a_write_resp: assert property (@(posedge clk_i) disable iff (!nrst_i)
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");

  a_zero_tap2_off: assert property (@(posedge clk_i) disable iff (!nrst_i)
    sample_stb_i && coef.tap[1] == COEF_RST |=> !tap_active_o[1]
      && coeffs_o.tap[1] == COEF_RST)
    else $error("zero tap 2 still active");

  a_bad_addr_keep: assert property (@(posedge clk_i) disable iff (!nrst_i)
    do_wr && !wr_dec[2] |=> coef == $past(coef))
    else $error("refused write changed a coefficient");

  a_pending_set: assert property (@(posedge clk_i) disable iff (!nrst_i)
    do_wr && wr_dec[2] && w_lane0 |=> pending_o)
    else $error("pending not set by write");

endmodule : hetap_regs

// ### common/hetap_pkg.sv
// Package: constants and types for the echo tap coefficient bank
// Functional notes
// - Tap 1 coefficient: 8-bit read/write register at index 45.
// - Tap 2 coefficient: 8-bit read/write register at index 46.
// - Tap 3 coefficient: 8-bit read/write register at index 47.
// - Tap 4 coefficient: 8-bit read/write register at index 48.
// - An all-zero coefficient makes its filter stage contribute nothing.
// - All four coefficients clear to zero on reset.
// - Software reads and writes each coefficient; value steers the hybrid.
package hetap_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int NTAPS    = 4;
  localparam int COEF_W   = 8;
  localparam int DATA_W   = 32;

  // ****************************************
  // Register indices; byte address is four times the index
  // ****************************************
  localparam logic [7:0] IDX_TAP1   = 8'h2D;
  localparam logic [7:0] IDX_TAP2   = 8'h2E;
  localparam logic [7:0] IDX_TAP3   = 8'h2F;
  localparam logic [7:0] IDX_TAP4   = 8'h30;
  localparam logic [7:0] IDX_STATUS = 8'h31;
  localparam int         STAT_PEND  = 0;

  // ****************************************
  // Reset values and bus answers
  // ****************************************
  localparam logic [COEF_W-1:0] COEF_RST = 8'h00;
  localparam logic [1:0]        RESP_OK  = 2'h0;
  localparam logic [1:0]        RESP_DEC = 2'h3;

  // ****************************************
  // Coefficient bundle, tap 1 in element 0
  // ****************************************
  typedef struct packed {
    logic [NTAPS-1:0][COEF_W-1:0] tap;
  } hetap_coeff_t;

endpackage : hetap_pkg

// ### testbench/hetap_regs_test.sv
// Testbench: echo tap coefficient registers over AXI4-Lite
`timescale 1ns/10ps
module hetap_regs_test
  import hetap_pkg::*;
;
  // ****************************************
  // Signals and table
  // ****************************************
  typedef struct packed {
    logic [9:0]  a;
    logic [31:0] d;
    logic [1:0]  r;
    logic [7:0]  q;
  } hetap_row_t;
  logic clk_i = 1'b0, nrst_i = 1'b0, sample_stb_i = 1'b0;
  hetap_coeff_t      coeffs_o;
  logic [NTAPS-1:0]  tap_active_o;
  logic              pending_o, s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic              s_axi_arready, s_axi_rvalid;
  logic [9:0]        s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]       s_axi_wdata = '0;
  logic [31:0]       s_axi_rdata;
  logic [3:0]        s_axi_wstrb = '0;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  int                num_errors = 0, compares = 0;
  hetap_row_t        rows [7] = '{
    '{10'h0B4, 32'hFFFFFF5A, RESP_OK, 8'h5A}, '{10'h0B8, 32'h123456A5, RESP_OK, 8'hA5},
    '{10'h0BC, 32'h00000080, RESP_OK, 8'h80}, '{10'h0C0, 32'h00000001, RESP_OK, 8'h01},
    '{10'h100, 32'h00000077, RESP_DEC, 8'h00}, '{10'h0B5, 32'h00000066, RESP_DEC, 8'h00},
    '{10'h0C4, 32'h000000FE, RESP_OK, 8'h01}};

  // Design under test
  hetap_regs #(.ADDR_W(10)) i_hetap_regs (
    .clk_i(clk_i), .nrst_i(nrst_i), .sample_stb_i(sample_stb_i), .coeffs_o(coeffs_o),
    .tap_active_o(tap_active_o), .pending_o(pending_o), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic give_verdict;
    $display("Comparisons %0d, mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : give_verdict

  // Bus write; each channel released at its own handshake
  task automatic axi_wr(input logic [9:0] a, input logic [31:0] d, input logic [3:0] s,
                        output logic [1:0] r);
    @(posedge clk_i);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_wstrb   <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_wr

  // Bus read; data taken at the edge that sees rvalid
  task automatic axi_rd(input logic [9:0] a, output logic [31:0] q, output logic [1:0] r);
    @(posedge clk_i);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do begin
      @(posedge clk_i);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    q = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_rd

  // One sample strobe, outputs settled on return
  task automatic strobe;
    @(posedge clk_i);
    sample_stb_i <= 1'b1;
    @(posedge clk_i);
    sample_stb_i <= 1'b0;
    #1;
  endtask : strobe

  // ****************************************
  // Clock, watchdog and tests
  // ****************************************
  initial begin
    forever #10 clk_i = ~clk_i;
  end

  initial begin
    #(20 * 5000);
    num_errors++;
    give_verdict();
  end

  initial begin
    logic [1:0]  r;
    logic [31:0] q;
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    chk("coeffs reset", 32'h0, coeffs_o);
    chk("active reset", 32'(tap_active_o), 32'h0);
    for (int i = 0; i < NTAPS; i++) begin
      axi_rd(10'h0B4 + 10'(4 * i), q, r);
      chk("tap reset", 32'h0, q);
    end
    $display("test reset done");
    // Table of writes and read-backs
    foreach (rows[k]) begin
      axi_wr(rows[k].a, rows[k].d, 4'hF, r);
      chk("bresp", 32'(rows[k].r), 32'(r));
      axi_rd(rows[k].a, q, r);
      chk("rdata", {24'h0, rows[k].q}, q);
      chk("rresp", 32'(rows[k].r), 32'(r));
    end
    $display("test table done");
    chk("pending set", 32'h1, 32'(pending_o));
    strobe();
    chk("coeffs applied", 32'h0180A55A, coeffs_o);
    chk("active all", 32'hF, 32'(tap_active_o));
    chk("pending clear", 32'h0, 32'(pending_o));
    // Zero coefficient drops its tap
    axi_wr(10'h0B8, 32'h0, 4'hF, r);
    strobe();
    chk("coeffs tap2 zero", 32'h0180005A, coeffs_o);
    chk("active tap2 off", 32'hD, 32'(tap_active_o));
    $display("test sample done");
    // Low byte strobe clear stores nothing
    axi_wr(10'h0B4, 32'h33, 4'hE, r);
    chk("bresp no strobe", 32'(RESP_OK), 32'(r));
    axi_rd(10'h0B4, q, r);
    chk("tap1 kept", 32'h5A, q);
    // Stored value read back before it is applied
    axi_wr(10'h0BC, 32'h44, 4'hF, r);
    axi_rd(10'h0BC, q, r);
    chk("tap3 stored", 32'h44, q);
    chk("tap3 not applied", 32'h0180005A, coeffs_o);
    axi_rd(10'h0C4, q, r);
    chk("status pending", 32'h1, q);
    $display("test awkward done");
    // Reset in mid-run
    @(posedge clk_i);
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    #1;
    chk("coeffs rerst", 32'h0, coeffs_o);
    chk("pending rerst", 32'h0, 32'(pending_o));
    axi_rd(10'h0BC, q, r);
    chk("tap3 rerst", 32'h0, q);
    strobe();
    chk("coeffs zero applied", 32'h0, coeffs_o);
    chk("active none", 32'h0, 32'(tap_active_o));
    $display("test second reset done");
    give_verdict();
  end
endmodule : hetap_regs_test
